// ===== logic/spi_byte_master.sv
// Legacy byte-oriented serial master with a classic Wishbone slave port.
// Assumes an external slave on the serial lines; slave select is done by
// software on general-purpose pins. The slave input is sampled from an
// asynchronous pin and passes two flip-flops first.
//
// Contract
// [RL1] Write of first byte starts transfer
// [RL2] Two-deep transmit queue, written order kept
// [RL3] Each byte out shifts one byte in
// [RL4] Receive staging slot behind readable register
// [RL5] Byte-done raised on each receive delivery; code raises it only on delivery to the readable register
// [RL6] Read moves staged byte, fresh event
// [RL7] Idle when both transmit slots empty
// [RL8] Short delay before receive delivery
// [RL9] Software clears byte-done after every byte
// [RL10] No slave select output provided
// [RL11] All four clock modes supported
// [RL12] Pin selects hold 0..31, reset ones
// [RL13] Pin selects act only while enabled
// [RL14] Software sets pins before enabling
// [RL15] Clock pin must map to real pin
// [RL16] Shared registers keep values when disabled
// [RL17] Enable register value one enables block
// [RL18] Set and clear words gate interrupt
// [RL19] Byte-done register marks byte exchanged
// [RL20] Bit rate coded, resets to one megabit
// [RL21] Bit order field selects msb or lsb
// [RL22] Phase selects sampling edge
// [RL23] Polarity selects idle clock level
// [RL24] Flag sticks until zero written
// [RL25] Writes to full queue ignored
`timescale 1ns/10ps
`include "spi_byte_defines.svh"

module spi_byte_master #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Serial lines
    output logic sck_o,
    output logic sck_oe_o,
    output logic mosi_o,
    output logic mosi_oe_o,
    input wire logic miso_i,
    // Interrupt request
    output logic irq_o
);

    // Elaboration check: the address must reach the highest offset
    if (ADDR_W < 12) begin : g_addr_too_narrow
        $error("ADDR_W must cover offsets up to 0x554");
    end

    // Half-bit time in clocks from the rate code; unknown codes run 1 Mbps
    function automatic logic [7:0] half_of(input logic [31:0] code);
        case (code)
            `RATE_125K: half_of = `HALF_125K;
            `RATE_250K: half_of = `HALF_250K;
            `RATE_500K: half_of = `HALF_500K;
            `RATE_2M: half_of = `HALF_2M;
            `RATE_4M: half_of = `HALF_4M;
            `RATE_8M: half_of = `HALF_8M;
            default: half_of = `HALF_1M;
        endcase
    endfunction

    // A pin select names a pin only with a value 0..31
    function automatic logic pin_ok(input logic [31:0] psel);
        pin_ok = (psel[31:5] == 27'h0);
    endfunction

    spi_byte_pkg::state_s r_r;
    spi_byte_pkg::state_s r_nxt;
    logic miso_s1_r;
    logic miso_s2_r;

    // Two-stage synchroniser for the slave input pin
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            miso_s1_r <= 1'b0;
            miso_s2_r <= 1'b0;
        end else begin
            miso_s1_r <= miso_i;
            miso_s2_r <= miso_s1_r;
        end
    end

    logic [ADDR_W-1:0] ofs;
    logic req;
    logic wr;
    logic rd;
    logic on;
    logic clock_polarity;
    logic clock_phase;
    logic lsb;
    logic bit_in;
    logic [7:0] half;
    logic [7:0] wbyte;

    assign ofs = {adr_i[ADDR_W-1:2], 2'b00};
    assign req = cyc_i && stb_i && !r_r.ack;
    assign wr = req && we_i;
    assign rd = req && !we_i;
    assign wbyte = sel_i[0] ? dat_i[7:0] : 8'h00;

    // Next-state logic for registers, queue and shifter
    always_comb begin
        r_nxt = r_r;
        // [RL17] enable field decode
        on = (r_r.enable == `ENABLE_ON);
        // [RL11] mode fields
        clock_polarity = r_r.fmt[`FMT_POL_BIT];
        clock_phase = r_r.fmt[`FMT_PHASE_BIT];
        lsb = r_r.fmt[`FMT_ORDER_BIT];
        half = half_of(r_r.rate);
        bit_in = pin_ok(r_r.psel_in) ? miso_s2_r : 1'b0;
        r_nxt.ack = req;
        r_nxt.rdat = 32'h0;

        // Register writes; byte lane 0 carries the narrow fields, pin selects and rate need all four lanes
        if (wr) begin
            case (ofs)
                // [RL24] only a zero write clears the flag
                `OFS_BYTE_DONE:
                    if (sel_i[0] && !dat_i[0]) r_nxt.done_flag = 1'b0;
                // [RL18] set and clear of interrupt enable
                `OFS_IRQ_SET:
                    if (sel_i[0] && dat_i[`IRQ_BIT]) r_nxt.irq_en = 1'b1;
                `OFS_IRQ_CLR:
                    if (sel_i[0] && dat_i[`IRQ_BIT]) r_nxt.irq_en = 1'b0;
                `OFS_ENABLE:
                    if (sel_i[0]) r_nxt.enable = dat_i[3:0];
                // [RL12] full 32-bit pin select words
                `OFS_CLK_PSEL: if (&sel_i) r_nxt.psel_clk = dat_i;
                `OFS_OUT_PSEL: if (&sel_i) r_nxt.psel_out = dat_i;
                `OFS_IN_PSEL: if (&sel_i) r_nxt.psel_in = dat_i;
                // [RL20] rate code word
                `OFS_BIT_RATE: if (&sel_i) r_nxt.rate = dat_i;
                `OFS_FORMAT: if (sel_i[0]) r_nxt.fmt = dat_i[2:0];
                // [RL2] queue write in order; [RL25] full queue ignores
                `OFS_TX_BYTE: begin
                    if (r_r.tx_cnt == 2'd0) begin
                        r_nxt.tx_q0 = wbyte;
                        r_nxt.tx_cnt = 2'd1;
                    end else if (r_r.tx_cnt == 2'd1) begin
                        r_nxt.tx_q1 = wbyte;
                        r_nxt.tx_cnt = 2'd2;
                    end
                end
                default: ;
            endcase
        end

        // Register reads
        if (rd) begin
            case (ofs)
                // [RL19] byte exchanged indication
                `OFS_BYTE_DONE: r_nxt.rdat = {31'h0, r_r.done_flag};
                `OFS_IRQ_SET, `OFS_IRQ_CLR:
                    r_nxt.rdat = {29'h0, r_r.irq_en, 2'b00};
                `OFS_ENABLE: r_nxt.rdat = {28'h0, r_r.enable};
                `OFS_CLK_PSEL: r_nxt.rdat = r_r.psel_clk;
                `OFS_OUT_PSEL: r_nxt.rdat = r_r.psel_out;
                `OFS_IN_PSEL: r_nxt.rdat = r_r.psel_in;
                `OFS_RX_BYTE: r_nxt.rdat = {24'h0, r_r.rx_reg};
                `OFS_TX_BYTE: r_nxt.rdat = {24'h0, r_r.tx_q0};
                `OFS_BIT_RATE: r_nxt.rdat = r_r.rate;
                `OFS_FORMAT: r_nxt.rdat = {29'h0, r_r.fmt};
                default: r_nxt.rdat = 32'h0;
            endcase
            // [RL6] reading hands over the staged byte with a new event
            if (ofs == `OFS_RX_BYTE && r_r.rx_stage_v) begin
                r_nxt.rx_reg = r_r.rx_stage;
                r_nxt.rx_stage_v = 1'b0;
                r_nxt.done_flag = 1'b1;
            end
        end

        // Serial engine
        case (r_r.phase)
            spi_byte_pkg::ST_IDLE: begin
                r_nxt.sck = clock_polarity;
                // [RL1] start on first queued byte while enabled
                if (on && r_r.tx_cnt != 2'd0) begin
                    r_nxt.sh_tx = r_r.tx_q0;
                    r_nxt.edges = 4'h0;
                    r_nxt.tick = 8'h0;
                    r_nxt.phase = spi_byte_pkg::ST_SHIFT;
                    // [RL22] phase 0 presents the first bit before any edge
                    if (!clock_phase) r_nxt.mosi = lsb ? r_r.tx_q0[0] : r_r.tx_q0[7];
                end
            end
            spi_byte_pkg::ST_SHIFT: begin
                if (!on) begin
                    r_nxt.phase = spi_byte_pkg::ST_IDLE;
                end else if (r_r.tick + 8'h1 >= half) begin
                    r_nxt.tick = 8'h0;
                    r_nxt.sck = ~r_r.sck;
                    r_nxt.edges = r_r.edges + 4'h1;
                    // [RL22] even edge index leads, odd trails
                    if (r_r.edges[0] == clock_phase) begin
                        // [RL3] sample edge shifts one bit in
                        r_nxt.sh_rx = lsb ? {bit_in, r_r.sh_rx[7:1]}
                                          : {r_r.sh_rx[6:0], bit_in};
                    end else if (clock_phase) begin
                        // [RL21] shift on leading edge, order chosen
                        r_nxt.mosi = lsb ? r_r.sh_tx[0] : r_r.sh_tx[7];
                        r_nxt.sh_tx = lsb ? {1'b0, r_r.sh_tx[7:1]}
                                          : {r_r.sh_tx[6:0], 1'b0};
                    end else if (r_r.edges != 4'hf) begin
                        r_nxt.sh_tx = lsb ? {1'b0, r_r.sh_tx[7:1]}
                                          : {r_r.sh_tx[6:0], 1'b0};
                        r_nxt.mosi = lsb ? r_r.sh_tx[1] : r_r.sh_tx[6];
                    end
                    if (r_r.edges == 4'hf) begin
                        r_nxt.phase = spi_byte_pkg::ST_SETTLE;
                    end
                end else begin
                    r_nxt.tick = r_r.tick + 8'h1;
                end
            end
            spi_byte_pkg::ST_SETTLE: begin
                // [RL8] short delay before delivery
                if (r_r.tick + 8'h1 >= `DONE_DELAY) begin
                    r_nxt.tick = 8'h0;
                    // [RL4] deliver to readable or staging slot
                    if (!r_r.done_flag && !r_r.rx_stage_v) begin
                        r_nxt.rx_reg = r_r.sh_rx;
                        // [RL5] event on each delivery to the readable register
                        r_nxt.done_flag = 1'b1;
                    end else begin
                        r_nxt.rx_stage = r_r.sh_rx;
                        r_nxt.rx_stage_v = 1'b1;
                    end
                    // [RL2] pop the sent byte, next one moves up
                    // A queue write in this same cycle is kept: it sits
                    // in the next-state copy of the second slot
                    r_nxt.tx_q0 = r_nxt.tx_q1;
                    r_nxt.tx_cnt = r_nxt.tx_cnt - 2'd1;
                    // [RL7] back to idle after every byte, restarts from idle if more are queued
                    r_nxt.phase = spi_byte_pkg::ST_IDLE;
                end else begin
                    r_nxt.tick = r_r.tick + 8'h1;
                end
            end
            default: r_nxt.phase = spi_byte_pkg::ST_IDLE;
        endcase

        // [RL23] clock idles at polarity level
        if (r_nxt.phase == spi_byte_pkg::ST_IDLE) r_nxt.sck = clock_polarity;
        // [RL13] pins drive only while enabled and mapped
        r_nxt.sck_oe = on && pin_ok(r_r.psel_clk);
        r_nxt.mosi_oe = on && pin_ok(r_r.psel_out);
        // [RL24] interrupt while flag and enable both set
        r_nxt.irq = r_nxt.done_flag && r_nxt.irq_en;
    end

    // State register; pin selects reset to all ones
    // [RL16] only reset clears registers, disabling keeps them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r_r <= '0;
            r_r.psel_clk <= `PSEL_RESET;
            r_r.psel_out <= `PSEL_RESET;
            r_r.psel_in <= `PSEL_RESET;
            r_r.rate <= `RATE_RESET;
            r_r.phase <= spi_byte_pkg::ST_IDLE;
        end else begin
            r_r <= r_nxt;
        end
    end

    // [RL10] no slave select among the outputs
    assign dat_o = r_r.rdat;
    assign ack_o = r_r.ack;
    assign sck_o = r_r.sck;
    assign sck_oe_o = r_r.sck_oe;
    assign mosi_o = r_r.mosi;
    assign mosi_oe_o = r_r.mosi_oe;
    assign irq_o = r_r.irq;

endmodule // spi_byte_master

// ===== logic/spi_byte_defines.svh
// Register offsets, field positions, reset values and rate codes for the
// legacy byte-oriented serial master. Definitions only.
`ifndef SPI_BYTE_DEFINES_SVH
`define SPI_BYTE_DEFINES_SVH

`define OFS_BYTE_DONE 12'h108
`define OFS_IRQ_SET 12'h304
`define OFS_IRQ_CLR 12'h308
`define OFS_ENABLE 12'h500
`define OFS_CLK_PSEL 12'h508
`define OFS_OUT_PSEL 12'h50c
`define OFS_IN_PSEL 12'h510
`define OFS_RX_BYTE 12'h518
`define OFS_TX_BYTE 12'h51c
`define OFS_BIT_RATE 12'h524
`define OFS_FORMAT 12'h554

`define IRQ_BIT 2
`define FMT_ORDER_BIT 0
`define FMT_PHASE_BIT 1
`define FMT_POL_BIT 2
`define ENABLE_ON 4'h1
`define PSEL_RESET 32'hffffffff
`define RATE_RESET 32'h10000000
`define RATE_125K 32'h02000000
`define RATE_250K 32'h04000000
`define RATE_500K 32'h08000000
`define RATE_1M 32'h10000000
`define RATE_2M 32'h20000000
`define RATE_4M 32'h40000000
`define RATE_8M 32'h80000000
// Half-bit times in system clocks (20 MHz); only the fastest code, 8M, gets 1
`define HALF_125K 8'h50
`define HALF_250K 8'h28
`define HALF_500K 8'h14
`define HALF_1M 8'h0a
`define HALF_2M 8'h05
`define HALF_4M 8'h02
`define HALF_8M 8'h01
// Short settle delay after last bit before the byte is delivered
`define DONE_DELAY 8'h02

`endif

// ===== logic/spi_byte_pkg.sv
// Types shared by the serial master: state encoding and state record.
// Does not use the constants header; widths of fields are written out here.
package spi_byte_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SHIFT,
        ST_SETTLE
    } phase_e;

    typedef struct packed {
        logic [3:0] enable;
        logic irq_en;
        logic done_flag;
        logic [31:0] psel_clk;
        logic [31:0] psel_out;
        logic [31:0] psel_in;
        logic [31:0] rate;
        logic [2:0] fmt;
        logic [7:0] tx_q0;
        logic [7:0] tx_q1;
        logic [1:0] tx_cnt;
        logic [7:0] rx_reg;
        logic [7:0] rx_stage;
        logic rx_stage_v;
        logic [7:0] sh_tx;
        logic [7:0] sh_rx;
        logic [3:0] edges;
        logic [7:0] tick;
        phase_e phase;
        logic sck;
        logic mosi;
        logic sck_oe;
        logic mosi_oe;
        logic irq;
        logic ack;
        logic [31:0] rdat;
    } state_s;

endpackage

// ===== verif/spi_byte_chk.sv
// Checker for the serial master: bus answer, clock pin enable, interrupt, clock.
// Sees only the top ports; shadows the few registers it needs from writes.
`timescale 1ns/10ps
`include "spi_byte_defines.svh"
module spi_byte_chk #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // Serial lines and interrupt
    input wire logic sck_o,
    input wire logic sck_oe_o,
    input wire logic mosi_o,
    input wire logic mosi_oe_o,
    input wire logic miso_i,
    input wire logic irq_o
);
    logic en_r, ien_r, pw_r, bad_r, wr, clr;
    logic [31:0] rate_r;
    logic [9:0] q_r;
    // A write lands at the edge where ack is seen
    assign wr = cyc_i && stb_i && we_i && ack_o;
    // A clear takes effect before ack shows, so the pending request counts
    assign clr = cyc_i && stb_i && we_i
        && (adr_i == `OFS_BYTE_DONE || adr_i == `OFS_IRQ_CLR);
    // Shadow registers; q_r counts quiet cycles since the last write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_r <= 1'b0;
            ien_r <= 1'b0;
            pw_r <= 1'b0;
            bad_r <= 1'b1;
            rate_r <= `RATE_1M;
            q_r <= 10'h3ff;
        end else begin
            q_r <= wr ? 10'h000 : (q_r == 10'h3ff ? q_r : q_r + 10'h001);
            if (wr && adr_i == `OFS_ENABLE)
                en_r <= dat_i[3:0] == `ENABLE_ON;
            if (wr && adr_i == `OFS_IRQ_SET && dat_i[`IRQ_BIT])
                ien_r <= 1'b1;
            if (wr && adr_i == `OFS_IRQ_CLR && dat_i[`IRQ_BIT])
                ien_r <= 1'b0;
            if (wr && adr_i >= `OFS_CLK_PSEL && adr_i <= `OFS_IN_PSEL)
                pw_r <= 1'b1;
            if (wr && adr_i == `OFS_CLK_PSEL)
                bad_r <= dat_i[31:5] != 27'h0;
            if (wr && adr_i == `OFS_BIT_RATE && sel_i == 4'hf)
                rate_r <= dat_i;
        end
    end
    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_ans;
        ack_o ##1 !ack_o;
    endsequence
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_bus_answer: assert property (s_req |=> s_ans)
        else $error("bus request not answered in one cycle");
    chk_unmapped_zero: assert property (ack_o && $past(!we_i)
        && $past(adr_i) < 12'h100 |-> dat_o == 32'h0)
        else $error("unmapped read not zero");
    chk_psel_reset: assert property (ack_o && !pw_r && $past(!we_i)
        && $past(adr_i) == `OFS_CLK_PSEL |-> dat_o == `PSEL_RESET)
        else $error("pin select reset value wrong");
    chk_oe_off: assert property ((!en_r || bad_r) [*3] |-> !sck_oe_o)
        else $error("clock pin driven while unused");
    chk_oe_on: assert property ((en_r && !bad_r) [*3] |-> sck_oe_o)
        else $error("clock pin not driven while mapped");
    chk_irq_mask: assert property (!ien_r [*2] |-> !irq_o)
        else $error("interrupt while masked");
    chk_irq_hold: assert property (irq_o && !clr && !$past(clr)
        |=> irq_o) else $error("interrupt dropped without clear");
    chk_sck_quiet: assert property (q_r >= 10'h258
        && rate_r == `RATE_1M |-> $stable(sck_o))
        else $error("clock runs with nothing queued");
    chk_sck_half: assert property (en_r && $past(en_r, 3)
        && rate_r == `RATE_1M && $changed(sck_o) |=> $stable(sck_o) [*3])
        else $error("clock half period too short");
endmodule // spi_byte_chk

bind spi_byte_master spi_byte_chk #(.ADDR_W(ADDR_W)) chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
    .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o), .miso_i(miso_i), .irq_o(irq_o)
);

// ===== verif/spi_slave_model.sv
// Behavioural serial slave: replies with the byte it received last.
// Assumes the clock line idles at the polarity level between frames.
`timescale 1ns/10ps
module spi_slave_model #(
    parameter logic [7:0] SEED = 8'h5a
) (
    // Serial lines and mode
    input wire logic sck_i,
    input wire logic mosi_i,
    input wire logic clock_polarity_i,
    input wire logic clock_phase_i,
    input wire logic lsb_i,
    // Slave output and what it saw
    output logic miso_o,
    output logic [7:0] got_o,
    output int nb_o
);
    int e = 0;
    logic [7:0] rep = SEED;
    logic [7:0] sh = 8'h00;
    logic drv = 1'b0;
    function automatic logic bit_at(input logic [7:0] r, input logic l,
                                    input int k);
        return l ? r[k] : r[7-k];
    endfunction
    initial begin
        got_o = 8'h00;
        nb_o = 0;
    end
    // First bit waits on the line before the first edge in phase 0
    assign miso_o = (e == 0 && !clock_phase_i) ? bit_at(rep, lsb_i, 0) : drv;
    // Sample and shift edges; idle moves ignored
    always @(sck_i) begin
        if (!(e == 0 && sck_i == clock_polarity_i)) begin
            if ((e % 2 == 0) != clock_phase_i)
                sh = lsb_i ? {mosi_i, sh[7:1]} : {sh[6:0], mosi_i};
            else
                drv = ((e + 1) / 2 < 8) ? bit_at(rep, lsb_i, (e + 1) / 2) : ~drv;
            e++;
            if (e == 16) begin
                e = 0;
                got_o = sh;
                rep = sh;
                nb_o++;
                drv = ~drv;
            end
        end
    end
endmodule // spi_slave_model

// ===== verif/spi_byte_master_test.sv
// Testbench: reset values, pin enables, four modes, queue and interrupt.
// Assumes one slave model on the serial lines at the default rate.
`timescale 1ns/10ps
`include "spi_byte_defines.svh"
module spi_byte_master_test;
    logic clk_i, rst_i, cyc, stb, we, clock_polarity, clock_phase, lsb;
    logic ack_o, sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_i, irq_o;
    logic [11:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, dat_o, q;
    logic [7:0] got, last;
    wire logic sck_ln, mosi_ln;
    int n_mismatch = 0, tests_run = 0, nb;
    // An unmapped pin floats: clock to idle, data to the inverse
    assign sck_ln = sck_oe_o ? sck_o : clock_polarity;
    assign mosi_ln = mosi_oe_o ? mosi_o : ~mosi_o;
    spi_byte_master DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
        .dat_o(dat_o), .ack_o(ack_o), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
        .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o), .miso_i(miso_i),
        .irq_o(irq_o));
    spi_slave_model #(.SEED(8'h5a)) slave (.sck_i(sck_ln), .mosi_i(mosi_ln),
        .clock_polarity_i(clock_polarity), .clock_phase_i(clock_phase), .lsb_i(lsb), .miso_o(miso_i),
        .got_o(got), .nb_o(nb));
    // 20 MHz system clock
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    task automatic summarize;
        $display("Compares %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e,
                       input string m);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // One classic cycle; the answer is taken at the edge showing ack
    task automatic wb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 20);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (k >= 20) begin
            chk(32'h0, 32'h1, "bus timeout");
            summarize();
        end
    endtask
    // Waits for the slave's byte count, then the settle and delivery
    task automatic wait_nb(input int n);
        int k;
        for (k = 0; k < 4000 && nb < n; k++) @(posedge clk_i);
        if (nb < n) begin
            chk(32'h0, 32'h1, "serial timeout");
            summarize();
        end
        tick(4);
    endtask
    task automatic t_regs;
        logic [11:0] a [10] = '{`OFS_CLK_PSEL, `OFS_OUT_PSEL, `OFS_IN_PSEL,
            `OFS_ENABLE, `OFS_BIT_RATE, `OFS_FORMAT, `OFS_RX_BYTE,
            `OFS_IRQ_SET, `OFS_BYTE_DONE, 12'h000};
        logic [31:0] e [10] = '{`PSEL_RESET, `PSEL_RESET, `PSEL_RESET,
            32'h0, `RATE_RESET, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
        for (int i = 0; i < 10; i++) begin
            wb(1'b0, a[i], 32'h0);
            chk(q, e[i], "reset value");
        end
        wb(1'b1, `OFS_CLK_PSEL, 32'h0);
        wb(1'b1, `OFS_ENABLE, 32'h2);
        tick(3);
        chk(32'(sck_oe_o), 32'h0, "enable two");
        wb(1'b1, `OFS_ENABLE, 32'h1);
        tick(3);
        chk(32'({sck_oe_o, mosi_oe_o}), 32'h2, "pin enables");
        wb(1'b1, `OFS_ENABLE, 32'h0);
        wb(1'b1, `OFS_OUT_PSEL, 32'h1);
        wb(1'b1, `OFS_IN_PSEL, 32'h2);
        wb(1'b0, `OFS_CLK_PSEL, 32'h0);
        chk(q, 32'h0, "pin kept");
        wb(1'b1, `OFS_IRQ_SET, 32'h4);
        wb(1'b0, `OFS_IRQ_CLR, 32'h0);
        chk(q, 32'h4, "irq enable read");
    endtask
    task automatic t_modes;
        logic [7:0] tx;
        for (int m = 0; m < 4; m++) begin
            clock_polarity = m[1];
            clock_phase = m[0];
            lsb = m[0] ^ m[1];
            tx = 8'h1d + 8'(m * 36);
            wb(1'b1, `OFS_ENABLE, 32'h0);
            wb(1'b1, `OFS_FORMAT, {29'h0, clock_polarity, clock_phase, lsb});
            wb(1'b1, `OFS_ENABLE, 32'h1);
            tick(12);
            chk(32'(sck_o), 32'(clock_polarity), "idle clock");
            wb(1'b1, `OFS_TX_BYTE, {24'h0, tx});
            wait_nb(m + 1);
            chk(32'(got), 32'(tx), "slave byte");
            wb(1'b0, `OFS_RX_BYTE, 32'h0);
            chk(q, 32'(last), "master byte");
            wb(1'b0, `OFS_BYTE_DONE, 32'h0);
            chk(q, 32'h1, "byte done");
            wb(1'b1, `OFS_BYTE_DONE, 32'h0);
            last = tx;
        end
    endtask
    task automatic t_queue;
        wb(1'b1, `OFS_TX_BYTE, 32'ha6);
        wb(1'b1, `OFS_TX_BYTE, 32'h9b);
        wait_nb(6);
        chk(32'(got), 32'h9b, "second byte last");
        chk(32'(irq_o), 32'h1, "irq with flag");
        wb(1'b1, `OFS_BYTE_DONE, 32'h0);
        tick(3);
        chk(32'(irq_o), 32'h0, "flag cleared");
        wb(1'b0, `OFS_RX_BYTE, 32'h0);
        chk(q, 32'(last), "first reply");
        tick(3);
        chk(32'(irq_o), 32'h1, "fresh event");
        wb(1'b0, `OFS_RX_BYTE, 32'h0);
        chk(q, 32'ha6, "staged reply");
        wb(1'b1, `OFS_IRQ_CLR, 32'h4);
        tick(3);
        chk(32'(irq_o), 32'h0, "irq masked");
        wb(1'b1, `OFS_BYTE_DONE, 32'h0);
        tick(700);
        chk(32'(nb), 32'h6, "clock stopped");
    endtask
    // Main sequence: reset for four cycles, then the scenarios
    initial begin
        rst_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 12'h000;
        sel = 4'hf;
        wdat = 32'h0;
        clock_polarity = 1'b0;
        clock_phase = 1'b0;
        lsb = 1'b0;
        last = 8'h5a;
        tick(4);
        rst_i <= 1'b0;
        t_regs();
        $display("registers done");
        t_modes();
        $display("modes done");
        t_queue();
        $display("queue done");
        summarize();
    end
endmodule // spi_byte_master_test
